//--- pkg/ddr3mr_pkg.sv
/*
 Shared constants for the DDR3 mode-register host controller: software
 register offsets, mode-register field positions, command encodings,
 timing figures and the controller state type.
 Assumes a 40 MHz system clock and a link clock divided down from it.
*/
package ddr3mr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // software register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MR0 = 8'h04;
    localparam logic [7:0] OFS_MR1 = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_LAT = 8'h10;

    // control register bits (write strobes except the odt request)
    localparam int CTRL_GO_MR0 = 0;
    localparam int CTRL_GO_MR1 = 1;
    localparam int CTRL_PD_ENTER = 2;
    localparam int CTRL_PD_EXIT = 3;
    localparam int CTRL_ODT = 4;

    // mode register 0 fields (address pin positions)
    localparam int MR0_BL = 0;
    localparam int MR0_CL_LSB = 2;
    localparam int MR0_BT = 3;
    localparam int MR0_CL = 4;
    localparam int MR0_TEST = 7;
    localparam int MR0_DLL_RST = 8;
    localparam int MR0_WR = 9;
    localparam int MR0_PPD = 12;
    localparam logic [1:0] BL_FIXED_BC4 = 2'h2;

    // mode register 1 fields
    localparam int MR1_DLL_OFF = 0;
    localparam int MR1_RTT0 = 2;
    localparam int MR1_AL = 3;
    localparam int MR1_RTT1 = 6;
    localparam int MR1_WLVL = 7;
    localparam int MR1_RSV8 = 8;
    localparam int MR1_RTT2 = 9;
    localparam int MR1_RSV10 = 10;
    localparam int MR1_QOFF = 12;
    localparam logic [1:0] AL_RESERVED = 2'h3;

    // status register bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_LOCK = 1;
    localparam int STAT_PD = 2;
    localparam int STAT_ERR = 3;
    localparam int STAT_NEED_RST = 7;

    // command pins {cs_n, ras_n, cas_n, we_n} and bank selects
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;

    // timing figures
    localparam int CLK_NS = 25;
    localparam int CK_HALF_DEF = 4;
    localparam int TDLLK_CK = 512;
    localparam int TMOD_CK = 12;
    localparam int TWR_NS = 15;
    localparam int TXP_NS = 6;
    localparam int TXPDLL_NS = 24;

    // controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ISSUE = 3'b001,
        ST_HOLD = 3'b010,
        ST_WAIT = 3'b011,
        ST_PD_IN = 3'b100,
        ST_PD = 3'b101,
        ST_PD_OUT = 3'b110
    } ddr3mr_state_e;

    // cas latency in clocks from {A6,A5,A4,A2}
    function automatic logic [4:0] ddr3mr_cl(input logic [3:0] code);
        ddr3mr_cl = 5'd4 + {2'b00, code[3:1]} + {1'b0, code[0], 3'b000};
    endfunction

    // write recovery in clocks from A11..A9
    function automatic logic [4:0] ddr3mr_wr(input logic [2:0] code);
        if (code == 3'h0) begin
            ddr3mr_wr = 5'd16;
        end else if (code <= 3'h4) begin
            ddr3mr_wr = {2'b00, code} + 5'd4;
        end else begin
            ddr3mr_wr = {1'b0, code, 1'b0};
        end
    endfunction

endpackage

//--- src/ddr3mr_ckgen.sv
/*
 Link clock generator: divides the system clock into the memory clock
 and marks each falling edge, where command pins may change.
 Assumes one synchronous active-high reset shared with the controller.
*/
module ddr3mr_ckgen import ddr3mr_pkg::*; #(
    parameter int HALF = CK_HALF_DEF
) (
    input wire logic clock,
    input wire logic reset,
    output logic ck_out,
    output logic ck_fall
);

    logic [7:0] div_reg;

    ////////////////////////////////////////////////////////////////////////
    // half-period divider; the pulse accompanies ck going low
    always_ff @(posedge clock) begin
        if (reset) begin
            div_reg <= 8'h00;
            ck_out <= 1'b0;
            ck_fall <= 1'b0;
        end else if (div_reg == 8'(HALF - 1)) begin
            div_reg <= 8'h00;
            ck_out <= ~ck_out;
            ck_fall <= ck_out;
        end else begin
            div_reg <= div_reg + 8'h01;
            ck_fall <= 1'b0;
        end
    end

endmodule

//--- src/ddr3mr_ctrl.sv
/*
 Host controller that loads DDR3 mode registers 0 and 1 with MRS
 commands, tracks DLL lock, precharge power-down and termination, and
 reports the resulting latencies to software over a simple port.
 Assumes the memory is initialised and idle when software asks for MRS.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
// Summary of operation
// - fixed chop pulls write references two clocks
// - on-the-fly chop keeps eight-beat write timing
// - mode register 0 bit A7 forced zero
// - reset dll after enable, wait lock
// - clock enable held high during lock
// - write recovery at least tWR in clocks
// - power-down exit waits tXPDLL or tXP
// - MRS with BA0 high loads register 1
// - register 1 reserved bits driven zero
// - leveling with outputs on limits termination
// - termination during writes limited to three
// - dll off keeps termination off
// - dll off needs dynamic termination off
// - MRS with all banks low loads register 0
module ddr3mr_ctrl import ddr3mr_pkg::*; #(
    parameter int CK_HALF = CK_HALF_DEF,
    parameter int TDLLK = TDLLK_CK
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_write,
    input wire logic sw_read,
    output logic [31:0] sw_rdata,
    output logic ddr_ck,
    output logic ddr_cke,
    output logic ddr_cs_n,
    output logic ddr_ras_n,
    output logic ddr_cas_n,
    output logic ddr_we_n,
    output logic [2:0] ddr_ba,
    output logic [14:0] ddr_addr,
    output logic ddr_odt
);

    // link clock period and derived cycle counts
    localparam int TCK_NS = 2 * CK_HALF * CLK_NS;
    localparam int WR_MIN = (TWR_NS + TCK_NS - 1) / TCK_NS;
    localparam int TXP_RAW = (TXP_NS + TCK_NS - 1) / TCK_NS;
    localparam int TXPDLL_RAW = (TXPDLL_NS + TCK_NS - 1) / TCK_NS;
    localparam logic [9:0] TXP_CNT = 10'((TXP_RAW < 1) ? 1 : TXP_RAW);
    localparam logic [9:0] TXPDLL_CNT = 10'((TXPDLL_RAW < 1) ? 1 : TXPDLL_RAW);
    localparam logic [9:0] TMOD_CNT = 10'(TMOD_CK);
    localparam logic [9:0] TDLLK_CNT = 10'(TDLLK);

    ddr3mr_state_e state_reg;
    logic ck_fall;
    logic [12:0] mr0_cfg_reg;
    logic [12:0] mr1_cfg_reg;
    logic [12:0] mr0_shadow_reg;
    logic [12:0] mr1_shadow_reg;
    logic [9:0] wait_reg;
    logic [9:0] lock_cnt_reg;
    logic lock_reg;
    logic need_rst_reg;
    logic odt_req_reg;
    logic [3:0] err_reg;
    logic [3:0] err_next;
    logic [2:0] cmd_ba_reg;
    logic [14:0] cmd_addr_reg;
    logic ctrl_wr;
    logic idle;
    logic [2:0] rtt;
    logic rtt_ok;
    logic mr0_ok;
    logic mr1_ok;
    logic go_mr0;
    logic go_mr1;
    logic [14:0] mr0_word;
    logic [14:0] mr1_word;
    logic [4:0] cl;
    logic [4:0] al;
    logic is_mrs;

    ddr3mr_ckgen #(.HALF(CK_HALF)) u_ckgen (
        .clock(clock),
        .reset(reset),
        .ck_out(ddr_ck),
        .ck_fall(ck_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // request checks on the configured mode words
    assign ctrl_wr = sw_write && (sw_addr == OFS_CTRL);
    assign idle = (state_reg == ST_IDLE);
    assign rtt = {mr1_cfg_reg[MR1_RTT2], mr1_cfg_reg[MR1_RTT1], mr1_cfg_reg[MR1_RTT0]};
    // only rzq/4, rzq/2, rzq/6 or off may be used with writes
    assign rtt_ok = (rtt <= 3'h3)
        || (mr1_cfg_reg[MR1_WLVL] && mr1_cfg_reg[MR1_QOFF]);
    assign mr0_ok = (ddr3mr_wr(mr0_cfg_reg[MR0_WR +: 3]) >= 5'(WR_MIN));
    assign mr1_ok = rtt_ok && (mr1_cfg_reg[MR1_AL +: 2] != AL_RESERVED);
    assign go_mr0 = ctrl_wr && sw_wdata[CTRL_GO_MR0] && idle && mr0_ok;
    assign go_mr1 = ctrl_wr && sw_wdata[CTRL_GO_MR1] && !sw_wdata[CTRL_GO_MR0]
        && idle && mr1_ok;
    // test mode and reserved positions never leave the controller
    assign mr0_word = {2'b00, mr0_cfg_reg[12:8], 1'b0, mr0_cfg_reg[6:0]};
    assign mr1_word = {2'b00, mr1_cfg_reg[12:11], 1'b0, mr1_cfg_reg[9],
        1'b0, mr1_cfg_reg[7:0]};
    assign is_mrs = ({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == CMD_MRS);

    // latencies from the words the memory really holds
    assign cl = ddr3mr_cl({mr0_shadow_reg[6:4], mr0_shadow_reg[MR0_CL_LSB]});
    always_comb begin
        case (mr1_shadow_reg[MR1_AL +: 2])
            2'h1: al = cl - 5'd1;
            2'h2: al = cl - 5'd2;
            default: al = 5'd0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: issue, hold one link clock, then wait out the delay
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            wait_reg <= 10'h000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (go_mr0 || go_mr1) begin
                        state_reg <= ST_ISSUE;
                    end else if (ctrl_wr && sw_wdata[CTRL_PD_ENTER] && !lock_reg) begin
                        state_reg <= ST_PD_IN;
                    end
                end
                ST_ISSUE: begin
                    if (ck_fall) begin
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (ck_fall) begin
                        state_reg <= ST_WAIT;
                        wait_reg <= TMOD_CNT - 10'h001;
                    end
                end
                ST_WAIT: begin
                    if (ck_fall) begin
                        if (wait_reg == 10'h000) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            wait_reg <= wait_reg - 10'h001;
                        end
                    end
                end
                ST_PD_IN: begin
                    if (ck_fall) begin
                        state_reg <= ST_PD;
                    end
                end
                ST_PD: begin
                    if (ctrl_wr && sw_wdata[CTRL_PD_EXIT]) begin
                        state_reg <= ST_PD_OUT;
                    end
                end
                ST_PD_OUT: begin
                    if (ck_fall) begin
                        state_reg <= ST_WAIT;
                        // slow exit waits for the frozen dll
                        wait_reg <= (mr0_shadow_reg[MR0_PPD] ? TXP_CNT : TXPDLL_CNT)
                            - 10'h001;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // latch the command word when a request is taken
    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_ba_reg <= BA_MR0;
            cmd_addr_reg <= 15'h0000;
        end else if (go_mr0) begin
            cmd_ba_reg <= BA_MR0;
            cmd_addr_reg <= mr0_word;
        end else if (go_mr1) begin
            cmd_ba_reg <= BA_MR1;
            cmd_addr_reg <= mr1_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command pins change only on the falling link clock
    always_ff @(posedge clock) begin
        if (reset) begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= CMD_NOP;
            ddr_ba <= 3'h0;
            ddr_addr <= 15'h0000;
            ddr_cke <= 1'b1;
        end else if (ck_fall) begin
            if (state_reg == ST_ISSUE) begin
                {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= CMD_MRS;
                ddr_ba <= cmd_ba_reg;
                ddr_addr <= cmd_addr_reg;
            end else begin
                {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= CMD_NOP;
            end
            if (state_reg == ST_PD_IN) begin
                ddr_cke <= 1'b0;
            end else if (state_reg == ST_PD_OUT) begin
                ddr_cke <= 1'b1;
            end
        end
    end

    // termination off during mrs, dll lock and dll-off operation
    always_ff @(posedge clock) begin
        if (reset) begin
            ddr_odt <= 1'b0;
        end else begin
            ddr_odt <= odt_req_reg && idle && !lock_reg
                && !mr1_shadow_reg[MR1_DLL_OFF];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow copies of what the memory holds after each mrs
    always_ff @(posedge clock) begin
        if (reset) begin
            mr0_shadow_reg <= 13'h0000;
            mr1_shadow_reg <= 13'h0000;
        end else if (ck_fall && (state_reg == ST_ISSUE)) begin
            if (cmd_ba_reg == BA_MR0) begin
                // the memory drops its dll reset bit by itself
                mr0_shadow_reg <= cmd_addr_reg[12:0] & ~(13'h0001 << MR0_DLL_RST);
            end else begin
                mr1_shadow_reg <= cmd_addr_reg[12:0];
            end
        end
    end

    // dll lock wait after a dll reset, and the reminder to reset
    always_ff @(posedge clock) begin
        if (reset) begin
            lock_reg <= 1'b0;
            lock_cnt_reg <= 10'h000;
            need_rst_reg <= 1'b0;
        end else if (ck_fall && (state_reg == ST_ISSUE)) begin
            if (cmd_ba_reg == BA_MR0 && cmd_addr_reg[MR0_DLL_RST]) begin
                lock_reg <= 1'b1;
                lock_cnt_reg <= TDLLK_CNT - 10'h001;
                need_rst_reg <= 1'b0;
            end else if (cmd_ba_reg == BA_MR1 && mr1_shadow_reg[MR1_DLL_OFF]
                && !cmd_addr_reg[MR1_DLL_OFF]) begin
                need_rst_reg <= 1'b1;
            end
        end else if (ck_fall && lock_reg) begin
            if (lock_cnt_reg == 10'h000) begin
                lock_reg <= 1'b0;
            end else begin
                lock_cnt_reg <= lock_cnt_reg - 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers; dll reset bit clears when the request is taken, a write wins
    always_ff @(posedge clock) begin
        if (reset) begin
            mr0_cfg_reg <= 13'h0000;
            mr1_cfg_reg <= 13'h0000;
            odt_req_reg <= 1'b0;
        end else begin
            if (sw_write && sw_addr == OFS_MR0) begin
                mr0_cfg_reg <= sw_wdata[12:0];
            end else if (go_mr0) begin
                mr0_cfg_reg[MR0_DLL_RST] <= 1'b0;
            end
            if (sw_write && sw_addr == OFS_MR1) begin
                mr1_cfg_reg <= sw_wdata[12:0];
            end
            if (ctrl_wr) begin
                odt_req_reg <= sw_wdata[CTRL_ODT];
            end
        end
    end

    // sticky errors {al, wr, rtt, test}: write one to clear, set wins
    always_comb begin
        err_next = err_reg;
        if (sw_write && sw_addr == OFS_STAT) begin
            err_next = err_reg & ~sw_wdata[STAT_ERR +: 4];
        end
        if (ctrl_wr && sw_wdata[CTRL_GO_MR0] && idle) begin
            err_next[0] = err_next[0] | mr0_cfg_reg[MR0_TEST];
            err_next[2] = err_next[2] | !mr0_ok;
        end
        if (ctrl_wr && sw_wdata[CTRL_GO_MR1] && !sw_wdata[CTRL_GO_MR0] && idle) begin
            err_next[1] = err_next[1] | !rtt_ok;
            err_next[3] = err_next[3] | (mr1_cfg_reg[MR1_AL +: 2] == AL_RESERVED);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            err_reg <= 4'h0;
        end else begin
            err_reg <= err_next;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (reset || !sw_read) begin
            sw_rdata <= 32'h0000_0000;
        end else if (sw_addr == OFS_CTRL) begin
            sw_rdata <= {27'h0000000, odt_req_reg, 4'h0};
        end else if (sw_addr == OFS_MR0) begin
            sw_rdata <= {19'h00000, mr0_cfg_reg};
        end else if (sw_addr == OFS_MR1) begin
            sw_rdata <= {19'h00000, mr1_cfg_reg};
        end else if (sw_addr == OFS_STAT) begin
            sw_rdata <= {24'h000000, need_rst_reg, err_reg, (state_reg == ST_PD),
                lock_reg, !idle};
        end else if (sw_addr == OFS_LAT) begin
            // fixed chop moves write references two clocks earlier
            sw_rdata <= {7'h00, (mr0_shadow_reg[1:0] == BL_FIXED_BC4),
                3'h0, 5'(al + cl), 3'h0, al, 3'h0, cl};
        end else begin
            sw_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the pins this controller drives and on the self-clearing dll reset request
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence mrs_window;
        is_mrs[*8] ##1 !is_mrs;
    endsequence

    sequence quiet_after_mrs;
        !is_mrs[*8];
    endsequence

    a_mr0_test_bit: assert property (is_mrs && ddr_ba == BA_MR0 |-> !ddr_addr[MR0_TEST])
        else $error("mode register 0 loaded with test bit set");
    a_mr1_reserved: assert property (is_mrs && ddr_ba == BA_MR1 |->
        !ddr_addr[MR1_RSV8] && !ddr_addr[MR1_RSV10] && ddr_addr[14:13] == 2'b00)
        else $error("mode register 1 reserved bit driven high");
    a_mrs_one_ck: assert property ($rose(is_mrs) |-> mrs_window)
        else $error("mrs not held for one link clock");
    a_mrs_spacing: assert property ($fell(is_mrs) |-> quiet_after_mrs)
        else $error("mrs commands too close");
    a_wr_minimum: assert property (is_mrs && ddr_ba == BA_MR0 |->
        ddr3mr_wr(ddr_addr[11:9]) >= 5'(WR_MIN))
        else $error("write recovery below minimum");
    a_rtt_leveling: assert property (is_mrs && ddr_ba == BA_MR1
        && ddr_addr[MR1_WLVL] && !ddr_addr[MR1_QOFF] |->
        {ddr_addr[MR1_RTT2], ddr_addr[MR1_RTT1], ddr_addr[MR1_RTT0]} <= 3'h3)
        else $error("illegal termination during leveling");
    a_lock_cke_high: assert property (lock_reg |-> ddr_cke && !ddr_odt)
        else $error("clock enable low or odt high during dll lock");
    a_dll_off_odt: assert property (mr1_shadow_reg[MR1_DLL_OFF] |=> !ddr_odt)
        else $error("odt driven while dll is off");
    a_pd_exit_wait: assert property ($rose(ddr_cke) |-> (state_reg == ST_WAIT)[*8])
        else $error("command window opened too early after power-down exit");
    a_dll_rst_clear: assert property (go_mr0 && mr0_cfg_reg[MR0_DLL_RST]
        && !(sw_write && sw_addr == OFS_MR0) |=> !mr0_cfg_reg[MR0_DLL_RST])
        else $error("dll reset request not cleared");

endmodule

//--- tb/ddr3mr_dev_model.sv
/*
 Device model of mode registers 0 and 1, loaded by MRS at link clock rise.
 Assumes the host controller drives the pins; raises viol on test or reserved bits, bad termination, BA2, odt in lock or dll off, or cke low in lock.
*/
module ddr3mr_dev_model #(
    parameter int TDLLK = 16
) (
    input wire logic ddr_ck,
    input wire logic ddr_cke,
    input wire logic ddr_cs_n,
    input wire logic ddr_ras_n,
    input wire logic ddr_cas_n,
    input wire logic ddr_we_n,
    input wire logic [2:0] ddr_ba,
    input wire logic [14:0] ddr_addr,
    input wire logic ddr_odt,
    output logic [14:0] mr0,
    output logic [14:0] mr1,
    output logic [4:0] cl,
    output logic [4:0] al,
    output logic viol
);
    timeunit 1ns;
    timeprecision 1ps;
    int lock_cnt = 0;
    logic mrs;
    logic [2:0] rtt;

    ////////////////////////////////////////////////////////////////////////
    // command decode and latency fields
    assign mrs = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == 4'h0;
    assign rtt = {ddr_addr[9], ddr_addr[6], ddr_addr[2]};
    assign cl = 5'h4 + {2'h0, mr0[6:4]} + {1'h0, mr0[2], 3'h0};
    assign al = (mr1[4:3] == 2'h1) ? cl - 5'h1 :
        (mr1[4:3] == 2'h2) ? cl - 5'h2 : 5'h0;

    initial begin
        mr0 = 15'h0;
        mr1 = 15'h0;
        viol = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // register loads and pin watch at each link clock rise
    always @(posedge ddr_ck) begin
        if (lock_cnt > 0) begin
            lock_cnt <= lock_cnt - 1;
            if (!ddr_cke || ddr_odt) viol <= 1'b1;
        end
        if (mr1[0] && ddr_odt) viol <= 1'b1;
        if (mrs && ddr_ba == 3'h0) begin
            mr0 <= ddr_addr & 15'h7EFF;
            if (ddr_addr[8]) lock_cnt <= TDLLK - 1;
            if (ddr_addr[7] || ddr_addr[14:13] != 2'h0) viol <= 1'b1;
        end
        if (mrs && ddr_ba == 3'h1) begin
            mr1 <= ddr_addr;
            if (ddr_addr[14:13] != 2'h0 || ddr_addr[10] || ddr_addr[8]) viol <= 1'b1;
            if (rtt > 3'h3 && !(ddr_addr[7] && ddr_addr[12])) viol <= 1'b1;
        end
        if (mrs && ddr_ba[2]) viol <= 1'b1;
    end
endmodule

//--- tb/testbench.sv
/*
 Self-checking bench for the mode-register host controller.
 Assumes the device model on the link pins and the package constants.
*/
module testbench import ddr3mr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock;
    logic reset;
    logic [7:0] sw_addr;
    logic [31:0] sw_wdata;
    logic sw_write;
    logic sw_read;
    logic [31:0] sw_rdata;
    logic ddr_ck;
    logic ddr_cke;
    logic ddr_cs_n;
    logic ddr_ras_n;
    logic ddr_cas_n;
    logic ddr_we_n;
    logic [2:0] ddr_ba;
    logic [14:0] ddr_addr;
    logic ddr_odt;
    logic [14:0] m_mr0;
    logic [14:0] m_mr1;
    logic [4:0] m_cl;
    logic [4:0] m_al;
    logic m_viol;
    int n_mismatch;
    int n_checks;

    ddr3mr_ctrl #(.CK_HALF(4), .TDLLK(16)) uut (
        .clock, .reset, .sw_addr, .sw_wdata, .sw_write, .sw_read, .sw_rdata,
        .ddr_ck, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n,
        .ddr_ba, .ddr_addr, .ddr_odt
    );
    ddr3mr_dev_model #(.TDLLK(16)) dev (
        .ddr_ck, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n,
        .ddr_ba, .ddr_addr, .ddr_odt, .mr0(m_mr0), .mr1(m_mr1), .cl(m_cl),
        .al(m_al), .viol(m_viol)
    );

    // 40 mhz system clock
    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    // bus cycles and compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge clock);
        sw_write <= 1'b0;
    endtask
    task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge clock);
        sw_read <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic wait_free(input logic [31:0] m);
        logic [31:0] s;
        for (int i = 0; i < 500; i++) begin
            sw_rd(OFS_STAT, s);
            if ((s & m) === 32'h0) break;
        end
        chk(s & m, 32'h0, "status stuck");
    endtask
    task automatic go(input logic [7:0] a, input logic [31:0] v, input logic [31:0] c);
        sw_wr(a, v);
        sw_wr(OFS_CTRL, c);
        wait_free(32'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        logic [31:0] d;
        sw_wr(8'h20, 32'hFFFF);
        sw_rd(8'h20, d);
        chk(d, 32'h0, "unmapped");
        sw_rd(OFS_STAT, d);
        chk(d, 32'h0, "status after reset");
        chk(32'({ddr_cke, ddr_odt}), 32'h2, "cke odt after reset");
    endtask
    task automatic t_mr0;
        logic [31:0] d;
        go(OFS_MR0, 32'h16AD, 32'h1);
        chk(32'(m_mr0), 32'h162D, "mr0 word");
        sw_rd(OFS_STAT, d);
        chk(32'(d[3]), 32'h1, "test bit flag");
        sw_wr(OFS_STAT, 32'h8);
        sw_rd(OFS_STAT, d);
        chk(32'(d[3]), 32'h0, "flag clear");
        sw_rd(OFS_LAT, d);
        chk(32'(d[4:0]), 32'hE, "cas latency");
    endtask
    task automatic t_al;
        logic [31:0] d;
        logic [4:0] sum [3] = '{5'hE, 5'h1B, 5'h1A};
        for (int k = 0; k < 4; k++) begin
            go(OFS_MR1, 32'h500 | 32'(k << 3), 32'h2);
            sw_rd(OFS_LAT, d);
            if (k < 3) begin
                chk(32'(m_mr1), 32'(k << 3), "mr1 reserved");
                chk(32'(d[12:8]), 32'(m_al), "additive latency");
                chk(32'(d[20:16]), 32'(sum[k]), "read latency");
            end else begin
                sw_rd(OFS_STAT, d);
                chk(32'({d[6], m_mr1}), 32'h8010, "al reserved");
            end
        end
        sw_wr(OFS_STAT, 32'h40);
    endtask
    task automatic t_rtt;
        logic [31:0] d;
        logic [31:0] v [4] = '{32'h200, 32'h280, 32'hC0, 32'h1280};
        for (int k = 0; k < 4; k++) begin
            go(OFS_MR1, v[k], 32'h2);
            sw_rd(OFS_STAT, d);
            chk(32'(d[4]), 32'(k < 2), "rtt refusal");
            sw_wr(OFS_STAT, 32'h10);
        end
        chk(32'(m_mr1), 32'h1280, "leveling outputs off");
    endtask
    task automatic t_chop;
        logic [31:0] d;
        go(OFS_MR0, 32'(BL_FIXED_BC4) | 32'h8, 32'h1);
        chk(32'(m_mr0[3:0]), 32'hA, "burst fields");
        sw_rd(OFS_LAT, d);
        chk(32'(d[24]), 32'h1, "fixed chop");
        go(OFS_MR0, 32'h1, 32'h1);
        sw_rd(OFS_LAT, d);
        chk(32'(d[24]), 32'h0, "chop per command");
    endtask
    task automatic t_dll;
        logic [31:0] d;
        sw_wr(OFS_MR0, 32'h100);
        sw_wr(OFS_CTRL, 32'h11);
        wait_free(32'h1);
        sw_rd(OFS_STAT, d);
        chk(32'(d[1]), 32'h1, "lock window");
        sw_wr(OFS_CTRL, 32'h14);
        wait_free(32'h2);
        sw_rd(OFS_STAT, d);
        chk(32'({d[2], ddr_cke}), 32'h1, "pd refused in lock");
        sw_rd(OFS_MR0, d);
        chk(d, 32'h0, "dll reset self clear");
        chk(32'(ddr_odt), 32'h1, "odt after lock");
    endtask
    task automatic t_pd;
        logic [31:0] d;
        sw_wr(OFS_CTRL, 32'h4);
        for (int i = 0; i < 80 && ddr_cke; i++) @(posedge clock);
        sw_rd(OFS_STAT, d);
        chk(32'({d[2], ddr_cke}), 32'h2, "in power-down");
        sw_wr(OFS_CTRL, 32'h8);
        wait_free(32'h5);
        chk(32'(ddr_cke), 32'h1, "power-down exit");
    endtask
    task automatic t_dll_off;
        logic [31:0] d;
        go(OFS_MR1, 32'h23, 32'h12);
        chk(32'(m_mr1), 32'h23, "drive strength");
        chk(32'(ddr_odt), 32'h0, "odt with dll off");
        go(OFS_MR1, 32'h0, 32'h12);
        chk(32'(m_mr1[0]), 32'h0, "dll enabled");
        sw_rd(OFS_STAT, d);
        chk(32'(d[7]), 32'h1, "dll reset needed");
        sw_wr(OFS_CTRL, 32'h0);
    endtask

    // verdict and end of run
    task automatic wrap_up;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        wrap_up();
    end

    // main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        sw_addr = 8'h0;
        sw_wdata = 32'h0;
        sw_write = 1'b0;
        sw_read = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_mr0();
        t_al();
        t_rtt();
        t_chop();
        t_dll();
        t_pd();
        t_dll_off();
        chk(32'(m_viol), 32'h0, "device misuse");
        wrap_up();
    end
endmodule
